// File: core/uartx_fifo.sv
// synchronous fifo with valid/ready on both sides and a fill count
`timescale 1ns/10ps
module uartx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64
) (
    input wire logic   clk,    // core clock
    input wire logic   rst_n,  // synchronised reset, active low
    uartx_fifo_if.store fif    // fill and drain side
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [AW:0]                 count;
    } uartx_fst_t;

    uartx_fst_t q;
    uartx_fst_t d;
    logic       push;
    logic       pop;

    // handshakes; depth is a power of two so the pointers wrap by themselves
    always_comb
    begin
        d          = q;
        fif.wready = (q.count != (AW+1)'(DEPTH));
        fif.rvalid = (q.count != '0);
        fif.rdata  = q.mem[q.rptr];
        fif.count  = q.count;
        push       = fif.wvalid & fif.wready;
        pop        = fif.rready & fif.rvalid;
        if (push)
        begin
            d.mem[q.wptr] = fif.wdata;
            d.wptr        = q.wptr + 1'b1;
        end
        if (pop)
        begin
            d.rptr = q.rptr + 1'b1;
        end
        d.count = q.count + (AW+1)'(push) - (AW+1)'(pop);
        // a flush drops everything, including a push in the same cycle
        if (fif.flush)
        begin
            d.wptr  = '0;
            d.rptr  = '0;
            d.count = '0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

endmodule : uartx_fifo

// File: core/uartx_fifo_if.sv
// fill and drain signals between the transmit logic and its fifo
`timescale 1ns/10ps
interface uartx_fifo_if #(parameter int WIDTH = 8, parameter int DEPTH = 64);
    localparam int CW = $clog2(DEPTH) + 1;
    logic [WIDTH-1:0] wdata;
    logic             wvalid;
    logic             wready;
    logic [WIDTH-1:0] rdata;
    logic             rvalid;
    logic             rready;
    logic             flush;
    logic [CW-1:0]    count;
    modport src   (output wdata, wvalid, rready, flush, input wready, rdata, rvalid, count);
    modport store (input wdata, wvalid, rready, flush, output wready, rdata, rvalid, count);
endinterface : uartx_fifo_if

// File: core/uartx_params.svh
// register offsets, field positions, reset values and counts of the uart transmit path
`ifndef UARTX_PARAMS_SVH
`define UARTX_PARAMS_SVH

// register offsets on the 4-bit host address
`define UTX_A_THR       4'h0
`define UTX_A_IER       4'h1
`define UTX_A_ISR_FCR   4'h2
`define UTX_A_LCR       4'h3
`define UTX_A_MCR       4'h4
`define UTX_A_LSR       4'h5
`define UTX_A_DLL       4'h6
`define UTX_A_DLM       4'h7
`define UTX_A_DLD       4'h8
`define UTX_A_ENHANCED_MODE_REG      4'h9
`define UTX_A_TRG       4'ha

// field positions
`define UTX_IER_TXE     1
`define UTX_FCR_EN      0
`define UTX_FCR_TXRST   2
`define UTX_LCR_STOP    2
`define UTX_LCR_PEN     3
`define UTX_LCR_EVEN    4
`define UTX_LCR_STICK   5
`define UTX_LCR_BREAK   6
`define UTX_MCR_PRE4    7
`define UTX_ENHANCED_MODE_REG_16X    7
`define UTX_LSR_THRE    5
`define UTX_LSR_TEMT    6

// reset values
`define UTX_DLL_RST     8'h01
`define UTX_DLM_RST     8'h00
`define UTX_DLD_RST     4'h0
`define UTX_LCR_RST     8'h03
`define UTX_REG_RST     8'h00
`define UTX_TRG_RST     7'h10

// isr read codes
`define UTX_ISR_NONE    8'h01
`define UTX_ISR_TXE     8'h02
`define UTX_ISR_FIFO    8'hc0

// counts
`define UTX_FIFO_DEPTH  64
`define UTX_PRE4_LAST   2'h3
`define UTX_OS16_LAST   4'hf
`define UTX_OS8_LAST    4'h7
`define UTX_WLEN_BASE   3'h4

`endif

// File: core/uartx_pkg.sv
// types shared by the uart transmit path
package uartx_pkg;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b010,
        TX_PAR   = 3'b011,
        TX_STOP  = 3'b100
    } uartx_txst_t;

    typedef struct packed {
        logic [7:0]  irq_enable_reg;
        logic [7:0]  lcr;
        logic [7:0]  modem_control_reg;
        logic [7:0]  dll;
        logic [7:0]  divisor_high_byte;
        logic [3:0]  divisor_fraction;
        logic [7:0]  enhanced_mode_reg;
        logic        fifo_en;
        logic [6:0]  trig;
        logic        wr_prev;
        logic [1:0]  pre_cnt;
        logic [16:0] brg_cnt;
        logic [3:0]  frac_acc;
        logic        extra;
        logic [3:0]  samp_cnt;
        uartx_txst_t st;
        logic [7:0]  shift;
        logic [2:0]  bit_idx;
        logic        par;
        logic [5:0]  cfg;
        logic        stop_idx;
        logic        txd;
        logic        txo;
        logic        irq;
        logic [7:0]  dout;
        logic        doe;
    } uartx_top_t;

endpackage : uartx_pkg

// File: core/uartx_tx_top.sv
// transmit path of one uart channel: host registers, fractional baud generator, fifo and shifter
`timescale 1ns/10ps
`include "uartx_params.svh"

module uartx_tx_top
    import uartx_pkg::*;
(
    input  wire logic       CORE_CLK,  // core clock, 20 MHz
    input  wire logic       RSTN,      // asynchronous reset, active low
    input  wire logic       CS_N,      // chip select, active low
    input  wire logic       WR_N,      // write strobe, active low
    input  wire logic       RD_N,      // read strobe, active low
    input  wire logic [3:0] ADDR,      // register address
    input  wire logic [7:0] DIN,       // write data from host
    output logic      [7:0] DOUT,      // read data to host
    output logic            DOE,       // read data drive enable
    output logic            TXD,       // serial output, idle high
    output logic            IRQ        // transmit interrupt, active high: holder empty, or fifo fill below the trigger with the fifo on
);

    uartx_top_t q;
    uartx_top_t d;
    logic       rst_meta_q;
    logic       rst_ok_q;
    logic       wr_stb;
    logic       rd_act;
    logic       pre_tick;
    logic       samp_tick;
    logic       bit_tick;
    logic [16:0] brg_last;
    logic [4:0]  frac_sum;
    logic [2:0]  wlen_last;
    logic        hold_empty;
    logic        tx_empty;
    logic        irq_pend;

    uartx_fifo_if #(.WIDTH(8), .DEPTH(`UTX_FIFO_DEPTH)) fif ();

    // holding fifo between the host and the shifter
    uartx_fifo #(
        .WIDTH (8),
        .DEPTH (`UTX_FIFO_DEPTH)
    ) u_fifo (
        .clk   (CORE_CLK),
        .rst_n (rst_ok_q),
        .fif   (fif.store)
    );

    // reset release through two flops; the rest of the block uses rst_ok_q
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rst_meta_q <= 1'b0;
            rst_ok_q   <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_ok_q   <= rst_meta_q;
        end
    end

    // flags and interrupt request seen by the host
    always_comb
    begin
        hold_empty = (fif.count == '0);
        tx_empty   = hold_empty && (q.st == TX_IDLE);
        irq_pend   = q.irq_enable_reg[`UTX_IER_TXE] &&
                     (q.fifo_en ? (fif.count < q.trig) : hold_empty);
    end

    // main next-state logic
    always_comb
    begin
        d          = q;
        fif.wdata  = DIN;
        fif.wvalid = 1'b0;
        fif.rready = 1'b0;
        fif.flush  = 1'b0;
        brg_last   = 17'h00000;
        frac_sum   = 5'h00;
        wlen_last  = `UTX_WLEN_BASE + {1'b0, q.cfg[1:0]};

        // a write is taken once, on the first cycle the strobe is seen low
        wr_stb    = !CS_N && !WR_N && !q.wr_prev;
        rd_act    = !CS_N && !RD_N;
        d.wr_prev = !CS_N && !WR_N;

        if (wr_stb)
        begin
            unique case (ADDR)
                `UTX_A_THR:
                begin
                    // without the fifo only one byte is held; a write onto a full holder is dropped
                    fif.wvalid = q.fifo_en || hold_empty;
                end
                `UTX_A_IER:     d.irq_enable_reg  = DIN;
                `UTX_A_ISR_FCR:
                begin
                    d.fifo_en = DIN[`UTX_FCR_EN];
                    // switching the fifo on or off empties it, as does the reset bit
                    fif.flush = DIN[`UTX_FCR_TXRST] || (DIN[`UTX_FCR_EN] != q.fifo_en);
                end
                `UTX_A_LCR:     d.lcr  = DIN;
                `UTX_A_MCR:     d.modem_control_reg  = DIN;
                `UTX_A_DLL:     d.dll  = DIN;
                `UTX_A_DLM:     d.divisor_high_byte  = DIN;
                `UTX_A_DLD:     d.divisor_fraction  = DIN[3:0];
                `UTX_A_ENHANCED_MODE_REG:    d.enhanced_mode_reg = DIN;
                `UTX_A_TRG:     d.trig = DIN[6:0];
                default:        d.wr_prev = !CS_N && !WR_N;                 // read-only or unmapped
            endcase
        end

        // prescaler: every cycle, or one cycle in four
        pre_tick = 1'b1;
        if (q.modem_control_reg[`UTX_MCR_PRE4])
        begin
            d.pre_cnt = q.pre_cnt + 2'h1;
            pre_tick  = (q.pre_cnt == `UTX_PRE4_LAST);
        end
        else
        begin
            d.pre_cnt = 2'h0;
        end

        // baud generator: period is the integer divisor, stretched by one when the
        // fraction accumulator overflows, so the mean period is int + dld/16
        brg_last  = (({q.divisor_high_byte, q.dll} == 16'h0000) ? 17'h00001 : {1'b0, q.divisor_high_byte, q.dll})
                    + 17'(q.extra) - 17'h00001;
        samp_tick = pre_tick && (q.brg_cnt >= brg_last);
        if (pre_tick)
        begin
            d.brg_cnt = samp_tick ? 17'h00000 : q.brg_cnt + 17'h00001;
        end
        if (samp_tick)
        begin
            frac_sum   = {1'b0, q.frac_acc} + {1'b0, q.divisor_fraction};
            d.frac_acc = frac_sum[3:0];
            d.extra    = frac_sum[4];
        end

        // bit timing: 16 or 8 sampling ticks per bit
        bit_tick = samp_tick &&
                   (q.samp_cnt == (q.enhanced_mode_reg[`UTX_ENHANCED_MODE_REG_16X] ? `UTX_OS16_LAST : `UTX_OS8_LAST));
        if (samp_tick)
        begin
            d.samp_cnt = bit_tick ? 4'h0 : q.samp_cnt + 4'h1;
        end

        // character sequencer
        unique case (q.st)
            TX_IDLE:
            begin
                d.txd = 1'b1;
                if (fif.rvalid)
                begin
                    fif.rready = 1'b1;
                    d.shift    = fif.rdata;
                    d.cfg      = q.lcr[5:0];
                    d.par      = !q.lcr[`UTX_LCR_EVEN];
                    d.samp_cnt = 4'h0;
                    d.txd      = 1'b0;
                    d.st       = TX_START;
                end
            end
            TX_START:
            begin
                if (bit_tick)
                begin
                    d.txd     = q.shift[0];
                    d.par     = q.par ^ q.shift[0];
                    d.shift   = {1'b0, q.shift[7:1]};
                    d.bit_idx = 3'h0;
                    d.st      = TX_DATA;
                end
            end
            TX_DATA:
            begin
                if (bit_tick)
                begin
                    if (q.bit_idx == wlen_last)
                    begin
                        if (q.cfg[`UTX_LCR_PEN])
                        begin
                            // stick parity sends the inverse of the even select
                            d.txd = q.cfg[`UTX_LCR_STICK] ? !q.cfg[`UTX_LCR_EVEN] : q.par;
                            d.st  = TX_PAR;
                        end
                        else
                        begin
                            d.txd      = 1'b1;
                            d.stop_idx = 1'b0;
                            d.st       = TX_STOP;
                        end
                    end
                    else
                    begin
                        d.txd     = q.shift[0];
                        d.par     = q.par ^ q.shift[0];
                        d.shift   = {1'b0, q.shift[7:1]};
                        d.bit_idx = q.bit_idx + 3'h1;
                    end
                end
            end
            TX_PAR:
            begin
                if (bit_tick)
                begin
                    d.txd      = 1'b1;
                    d.stop_idx = 1'b0;
                    d.st       = TX_STOP;
                end
            end
            TX_STOP:
            begin
                if (bit_tick)
                begin
                    if (q.cfg[`UTX_LCR_STOP] && !q.stop_idx)
                    begin
                        d.stop_idx = 1'b1;
                    end
                    else
                    begin
                        d.st = TX_IDLE;
                    end
                end
            end
            default:
            begin
                d.st  = TX_IDLE;
                d.txd = 1'b1;
            end
        endcase

        // registered outputs; break is folded in ahead of the flop so the pin cannot glitch
        d.txo  = d.txd && !d.lcr[`UTX_LCR_BREAK];
        d.irq  = irq_pend;
        d.doe  = rd_act;
        d.dout = 8'h00;
        if (rd_act)
        begin
            unique case (ADDR)
                `UTX_A_IER:     d.dout = q.irq_enable_reg;
                `UTX_A_ISR_FCR: d.dout = (irq_pend ? `UTX_ISR_TXE : `UTX_ISR_NONE) |
                                         (q.fifo_en ? `UTX_ISR_FIFO : 8'h00);
                `UTX_A_LCR:     d.dout = q.lcr;
                `UTX_A_MCR:     d.dout = q.modem_control_reg;
                `UTX_A_LSR:     d.dout = {1'b0, tx_empty, hold_empty, 5'h00};
                `UTX_A_DLL:     d.dout = q.dll;
                `UTX_A_DLM:     d.dout = q.divisor_high_byte;
                `UTX_A_DLD:     d.dout = {4'h0, q.divisor_fraction};
                `UTX_A_ENHANCED_MODE_REG:    d.dout = q.enhanced_mode_reg;
                `UTX_A_TRG:     d.dout = {1'b0, q.trig};
                default:        d.dout = 8'h00;
            endcase
        end
    end

    // state register; divisor comes out of reset at exactly one
    always_ff @(posedge CORE_CLK or negedge rst_ok_q)
    begin
        if (!rst_ok_q)
        begin
            q      <= '0;
            q.dll  <= `UTX_DLL_RST;
            q.divisor_high_byte  <= `UTX_DLM_RST;
            q.divisor_fraction  <= `UTX_DLD_RST;
            q.lcr  <= `UTX_LCR_RST;
            q.irq_enable_reg  <= `UTX_REG_RST;
            q.modem_control_reg  <= `UTX_REG_RST;
            q.enhanced_mode_reg <= `UTX_REG_RST;
            q.trig <= `UTX_TRG_RST;
            q.st   <= TX_IDLE;
            q.txd  <= 1'b1;
            q.txo  <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign DOUT = q.dout;
    assign DOE  = q.doe;
    assign TXD  = q.txo;
    assign IRQ  = q.irq;

endmodule : uartx_tx_top

// File: verif/uart_transmit_path_fractional_baud_test.sv
// self-checking bench for the uart transmit path
`timescale 1ns/10ps
`include "uartx_params.svh"
module uart_transmit_path_fractional_baud_test;
    logic       CORE_CLK = 1'b0;
    logic       RSTN     = 1'b0;
    logic       CS_N, WR_N, RD_N, DOE, TXD, IRQ;
    logic [3:0] ADDR;
    logic [7:0] DIN, DOUT, rv, lcr, d;
    logic [7:0] arr [65];
    logic       oe, em, pre, ie, lo;
    int         num_errors = 0;
    int         compares   = 0;
    int         i, j, n, divisor_fraction;
    real        bitc;

    always #25 CORE_CLK = ~CORE_CLK;

    uartx_tx_top dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .CS_N(CS_N), .WR_N(WR_N), .RD_N(RD_N),
                      .ADDR(ADDR), .DIN(DIN), .DOUT(DOUT), .DOE(DOE), .TXD(TXD), .IRQ(IRQ));
    uartx_host_model host (.CORE_CLK(CORE_CLK), .CS_N(CS_N), .WR_N(WR_N), .RD_N(RD_N),
                           .ADDR(ADDR), .DIN(DIN), .DOUT(DOUT), .DOE(DOE));

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] mask);
        host.rd(a, rv, oe);
        check("read enable", 8'h01, 8'(oe));
        check("register", exp & mask, rv & mask);
    endtask : rchk

    // line levels of one character from the start bit on; stop bits stay at the preset ones
    function automatic int frame_bits(input logic [7:0] dd, input logic [7:0] lc, output logic [11:0] b);
        int         k;
        logic [7:0] m;
        m = 8'hff >> (2'h3 - lc[1:0]);
        b = '1;
        b[0] = 1'b0;
        for (k = 0; k < 5 + lc[1:0]; k++) b[k+1] = dd[k];
        if (lc[3]) b[k+1] = lc[5] ? ~lc[4] : (lc[4] ? ^(dd & m) : ~^(dd & m));
        return k + 2 + lc[3] + lc[2];
    endfunction : frame_bits

    // sample each bit in its middle, reckoned from the observed start edge
    task automatic rx_check(input logic [7:0] dd, input logic [7:0] lc, input real bc, input bit fc, input int left);
        logic [11:0] b;
        int          nb, k, t;
        nb = frame_bits(dd, lc, b);
        t  = 0;
        while (TXD !== 1'b0 && t < 20000)
        begin
            @(negedge CORE_CLK);
            t++;
        end
        t = 0;
        for (k = 0; k < nb; k++)
        begin
            while (t < int'((k + 0.5) * bc))
            begin
                @(negedge CORE_CLK);
                t++;
            end
            check("txd bit", 8'(b[k]), 8'(TXD));
            if (k == 1 && fc) check("irq level", 8'(left < 16), 8'(IRQ));
        end
    endtask : rx_check

    task automatic test_done;
        if (num_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (90000) @(posedge CORE_CLK);
        num_errors++;
        test_done();
    end

    initial
    begin
        void'($urandom(531));
        repeat (12) @(posedge CORE_CLK);
        RSTN <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        rchk(`UTX_A_DLL, 8'h01, 8'hff);
        rchk(`UTX_A_DLM, 8'h00, 8'hff);
        rchk(`UTX_A_DLD, 8'h00, 8'h0f);
        rchk(`UTX_A_ISR_FCR, 8'h01, 8'hff);
        rchk(4'hb, 8'h00, 8'hff);
        // non-fifo characters with random framing, rate and fraction; first one a short stick-parity corner
        for (i = 0; i < 8; i++)
        begin
            lcr = (i == 0) ? 8'h3c : 8'($urandom & 32'h3f);
            n   = 1 + $urandom % 2;
            divisor_fraction = (i == 1) ? 15 : $urandom % 16;
            {em, pre, ie} = 3'($urandom);
            d   = 8'($urandom);
            bitc = (em ? 16.0 : 8.0) * (n + divisor_fraction / 16.0) * (pre ? 4 : 1);
            host.wr(`UTX_A_LCR, lcr);
            host.wr(`UTX_A_DLL, 8'(n));
            host.wr(`UTX_A_DLD, 8'(divisor_fraction));
            host.wr(`UTX_A_ENHANCED_MODE_REG, {em, 7'h0});
            host.wr(`UTX_A_MCR, {pre, 7'h0});
            host.wr(`UTX_A_IER, {6'h0, ie, 1'b0});
            rchk(`UTX_A_LSR, 8'h20, 8'h20);
            host.wr(`UTX_A_THR, d);
            fork
                rx_check(d, lcr, bitc, 1'b0, 0);
                begin
                    rchk(`UTX_A_LSR, 8'h20, 8'h60);
                    host.wr(`UTX_A_LCR, ~lcr & 8'h3f);
                end
            join
            repeat (int'(bitc)) @(posedge CORE_CLK);
            rchk(`UTX_A_LSR, 8'h60, 8'h60);
            check("irq enable", 8'(ie), 8'(IRQ));
        end
        // fifo mode: one more byte than the fifo holds is accepted, the next one is refused
        host.wr(`UTX_A_LCR, 8'h03);
        host.wr(`UTX_A_DLL, 8'h02);
        host.wr(`UTX_A_DLD, 8'h00);
        host.wr(`UTX_A_ENHANCED_MODE_REG, 8'h00);
        host.wr(`UTX_A_MCR, 8'h80);
        host.wr(`UTX_A_IER, 8'h02);
        host.wr(`UTX_A_ISR_FCR, 8'h01);
        rchk(`UTX_A_ISR_FCR, 8'hc2, 8'hff);
        for (i = 0; i < 65; i++) arr[i] = 8'($urandom);
        fork
            for (j = 0; j < 65; j++) rx_check(arr[j], 8'h03, 64.0, j > 0, 64 - j);
            begin
                for (i = 0; i < 66; i++) host.wr(`UTX_A_THR, (i < 65) ? arr[i] : 8'h5a);
                rchk(`UTX_A_LSR, 8'h00, 8'h60);
                check("irq full", 8'h00, 8'(IRQ));
            end
        join
        lo = 1'b0;
        repeat (700)
        begin
            @(negedge CORE_CLK);
            lo |= !TXD;
        end
        check("idle line", 8'h00, 8'(lo));
        rchk(`UTX_A_LSR, 8'h60, 8'h60);
        // break pulls the idle line low; a programmed trigger and a flush while the shifter is busy
        host.wr(`UTX_A_LCR, 8'h43);
        @(negedge CORE_CLK);
        check("break line", 8'h00, 8'(TXD));
        host.wr(`UTX_A_LCR, 8'h03);
        n = 1 + $urandom % 40;
        host.wr(`UTX_A_TRG, 8'(n));
        for (i = 0; i < 20; i++) host.wr(`UTX_A_THR, 8'($urandom));
        rchk(`UTX_A_LSR, 8'h00, 8'h60);
        check("irq trigger", 8'(n > 19), 8'(IRQ));
        host.wr(`UTX_A_ISR_FCR, 8'h05);
        rchk(`UTX_A_LSR, 8'h20, 8'h60);
        check("irq flushed", 8'h01, 8'(IRQ));
        repeat (700) @(posedge CORE_CLK);
        rchk(`UTX_A_LSR, 8'h60, 8'h60);
        test_done();
    end
endmodule : uart_transmit_path_fractional_baud_test

bind uartx_tx_top uartx_tx_top_sva chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .CS_N(CS_N), .WR_N(WR_N), .RD_N(RD_N),
                                        .ADDR(ADDR), .DIN(DIN), .DOUT(DOUT), .DOE(DOE), .TXD(TXD), .IRQ(IRQ));

// File: verif/uartx_host_model.sv
// host processor model on the parallel register bus
`timescale 1ns/10ps
module uartx_host_model (
    input  wire logic       CORE_CLK, // core clock
    output logic            CS_N,     // chip select
    output logic            WR_N,     // write strobe
    output logic            RD_N,     // read strobe
    output logic      [3:0] ADDR,     // register address
    output logic      [7:0] DIN,      // write data
    input  wire logic [7:0] DOUT,     // read data
    input  wire logic       DOE       // read drive enable
);
    initial
    begin
        CS_N = 1'b1;
        WR_N = 1'b1;
        RD_N = 1'b1;
        ADDR = 4'h0;
        DIN  = 8'h00;
    end

    // one strobe cycle, then a full idle cycle so the next write is seen as new
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        CS_N <= 1'b0;
        WR_N <= 1'b0;
        ADDR <= a;
        DIN  <= d;
        @(posedge CORE_CLK);
        CS_N <= 1'b1;
        WR_N <= 1'b1;
        ADDR <= ~a; // released lines must not keep the last value
        DIN  <= ~d;
    endtask : wr

    // data is taken in the cycle after the strobe is sampled
    task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic oe);
        @(posedge CORE_CLK);
        CS_N <= 1'b0;
        RD_N <= 1'b0;
        ADDR <= a;
        @(posedge CORE_CLK);
        CS_N <= 1'b1;
        RD_N <= 1'b1;
        ADDR <= ~a;
        @(negedge CORE_CLK);
        d  = DOUT;
        oe = DOE;
    endtask : rd
endmodule : uartx_host_model

// File: verif/uartx_tx_top_sva.sv
// port-level assertions for the uart transmit path
`timescale 1ns/10ps
module uartx_tx_top_sva (
    input wire logic       CORE_CLK, // core clock
    input wire logic       RSTN,     // reset, active low
    input wire logic       CS_N,     // chip select
    input wire logic       WR_N,     // write strobe
    input wire logic       RD_N,     // read strobe
    input wire logic [3:0] ADDR,     // register address
    input wire logic [7:0] DIN,      // write data
    input wire logic [7:0] DOUT,     // read data
    input wire logic       DOE,      // read drive enable
    input wire logic       TXD,      // serial out
    input wire logic       IRQ       // interrupt
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    logic wr_prev_q;
    logic ier_q;
    logic fen_q;
    logic brk_q;
    wire  wr_now = !CS_N && !WR_N && !wr_prev_q;
    wire  rd_now = !CS_N && !RD_N;

    // shadow of the control bits the checks need; the edge detect mirrors the bus
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            wr_prev_q <= 1'b0;
            ier_q     <= 1'b0;
            fen_q     <= 1'b0;
            brk_q     <= 1'b0;
        end
        else
        begin
            wr_prev_q <= !CS_N && !WR_N;
            if (wr_now && ADDR == 4'h1) ier_q <= DIN[1];
            if (wr_now && ADDR == 4'h2) fen_q <= DIN[0];
            if (wr_now && ADDR == 4'h3) brk_q <= DIN[6];
        end
    end

    a_read_drive: assert property (rd_now |=> DOE) else $error("read data not driven");
    a_idle_quiet: assert property (!rd_now |=> !DOE && DOUT == 8'h00) else $error("bus driven without read");
    a_reset_idle: assert property ($rose(RSTN) |-> (TXD && !IRQ)[*2]) else $error("outputs active in reset");
    a_irq_enable: assert property (!ier_q && !$past(ier_q) && !$past(ier_q, 2) |-> !IRQ)
        else $error("interrupt while disabled");
    // break only pulls the line low, so it may shorten a high run but never a low one
    a_start_min: assert property ($fell(TXD) && !brk_q |=> (!TXD)[*6])
        else $error("low run too short");
    a_high_min: assert property ($rose(TXD) && !brk_q && !$past(brk_q) |-> (TXD || brk_q)[*8])
        else $error("high run too short");
    a_lsr_order: assert property (rd_now && ADDR == 4'h5 |=> !DOUT[6] || DOUT[5])
        else $error("transmitter empty with data queued");
    a_isr_code: assert property (rd_now && ADDR == 4'h2 |=> DOUT[7:6] == {2{fen_q}}
        && (DOUT[5:0] == 6'h01 || DOUT[5:0] == 6'h02)) else $error("bad status code");
    a_unmapped_zero: assert property (rd_now && ADDR > 4'ha |=> DOUT == 8'h00) else $error("unmapped read not zero");

    c_frame: cover property ($fell(TXD));
    c_irq: cover property ($rose(IRQ));
    c_isr_fifo: cover property (rd_now && ADDR == 4'h2 && fen_q);
endmodule : uartx_tx_top_sva
